// ---- src/jtag_device_end.sv ----
// Device end of the test port: controller, instruction decode, data
// registers, boundary cells, pin control and offset registers.
// Assumes link pins come from outside this clock domain.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - External test: boundary chain drives outputs, captures inputs
// - Sample/preload: functional, boundary chain samples pins
// - Preloaded boundary values are used by external test
// - Identification: 32-bit code chain, device stays functional
// - After reset, data scan reads identification directly
// - Clamp: outputs from boundary chain, bypass selected
// - Clamp shifting leaves clamped outputs unchanged
// - High impedance: all outputs off, bypass selected
// - Offset read instruction captures both threshold offsets
// - Tester disables serial programming during offset read
// - Offset write instruction loads both threshold offsets
// - Tester disables serial programming during offset write
// - Bypass: one-bit stage, device fully functional
// - Tester holds link clock still during master reset
// - Four-bit instruction field, sixteen codes
// - Fixed instruction codes; other codes act as bypass
// - Bypass stage captures zero in capture-data
// - Power-down makes the test port ignore scans
module jtag_device_end #(
    parameter int              IN_N     = jtag_pkg::BSR_IN_N,
    parameter int              OUT_N    = jtag_pkg::BSR_OUT_N,
    parameter int              OW       = jtag_pkg::OFS_W,
    parameter logic [3:0]      ID_VER   = 4'h0,     // Arbitrary value
    parameter logic [15:0]     ID_PART  = 16'h5a17, // Arbitrary value
    parameter logic [10:0]     ID_MAKER = 11'h2c6   // Arbitrary value
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Link pins
    jtag_link_if.dut               link,
    // Functional core side
    input  wire logic [OUT_N-1:0]  core_out_in,
    input  wire logic [OUT_N-1:0]  core_oe_in,
    output logic      [IN_N-1:0]   core_in_out,
    // Package pins
    input  wire logic [IN_N-1:0]   pin_in_in,
    output logic      [OUT_N-1:0]  pin_out_out,
    output logic      [OUT_N-1:0]  pin_oe_out,
    // Power down, from a pin
    input  wire logic              power_down_input_in,
    // Threshold offsets, dedicated serial path and current values
    input  wire logic              ofs_load_in,
    input  wire logic [OW-1:0]     ofs_empty_in,
    input  wire logic [OW-1:0]     ofs_full_in,
    output logic      [OW-1:0]     almost_empty_flag_ofs_out,
    output logic      [OW-1:0]     almost_full_flag_ofs_out
);
    import jtag_pkg::*;

    localparam int BSR_N  = IN_N + OUT_N;
    localparam int DR_MAX = (BSR_N > 2 * OW) ?
                            ((BSR_N > ID_W) ? BSR_N : ID_W) :
                            ((2 * OW > ID_W) ? 2 * OW : ID_W);
    localparam logic [ID_W-1:0] ID_CODE =
        ({28'h0, ID_VER} << ID_VER_POS) | ({16'h0, ID_PART} << ID_PART_POS)
        | ({21'h0, ID_MAKER} << ID_MAKER_POS) | 32'h1;

    logic [2:0]        tck_sync_reg;
    logic [1:0]        tms_sync_reg;
    logic [1:0]        tdi_sync_reg;
    logic [1:0]        trst_sync_reg;
    logic [1:0]        pd_sync_reg;
    logic [IN_N-1:0]   pin_sync1_reg;
    logic [IN_N-1:0]   pin_sync2_reg;
    tap_state_t        tap_reg;
    logic [IR_W-1:0]   ir_shift_reg;
    logic [IR_W-1:0]   ir_reg;
    logic [DR_MAX-1:0] dr_shift_reg;
    logic [BSR_N-1:0]  bsr_upd_reg;
    logic              tdo_reg;
    logic              tdo_oe_reg;
    logic [OW-1:0]     ae_ofs_reg;
    logic [OW-1:0]     af_ofs_reg;
    logic [OUT_N-1:0]  pin_out_reg;
    logic [OUT_N-1:0]  pin_oe_reg;
    logic [IN_N-1:0]   core_in_reg;
    logic              tck_rise;
    logic              tck_fall;
    logic              tap_hold;
    dr_sel_t           sel;

    // Length of the chosen data register
    function automatic int dr_len(input dr_sel_t s);
        case (s)
            DR_BSR:  dr_len = BSR_N;
            DR_ID:   dr_len = ID_W;
            DR_OFS:  dr_len = 2 * OW;
            default: dr_len = 1;
        endcase
    endfunction : dr_len

    // Shift right by one, new bit entering at the top of the chain
    function automatic logic [DR_MAX-1:0] dr_shift(
        input logic [DR_MAX-1:0] v, input logic b, input int len);
        logic [DR_MAX-1:0] r;
        r = v >> 1;
        r[len-1] = b;
        return r;
    endfunction : dr_shift

    // Pin synchronisers, two flip-flops each; the link clock has a third for edge detection
    always_ff @(posedge clk_in) begin
        tck_sync_reg  <= {tck_sync_reg[1:0], link.tck};
        tms_sync_reg  <= {tms_sync_reg[0], link.tms};
        tdi_sync_reg  <= {tdi_sync_reg[0], link.tdi};
        trst_sync_reg <= {trst_sync_reg[0], link.trst_n};
        pd_sync_reg   <= {pd_sync_reg[0], power_down_input_in};
        pin_sync1_reg <= pin_in_in;
        pin_sync2_reg <= pin_sync1_reg;
    end

    assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
    assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
    assign tap_hold = pd_sync_reg[1];
    assign sel      = dr_select(ir_reg);

    // Controller state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !trst_sync_reg[1]) begin
            tap_reg <= TLR;
        end else if (tck_rise && !tap_hold) begin
            tap_reg <= tap_next(tap_reg, tms_sync_reg[1]);
        end
    end

    // Instruction path; reset selects identification
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !trst_sync_reg[1] || tap_reg == TLR) begin
            ir_reg       <= IR_IDCODE;
            ir_shift_reg <= IR_CAPTURE;
        end else if (tck_rise && !tap_hold) begin
            if (tap_reg == CAP_IR) begin
                ir_shift_reg <= IR_CAPTURE;
            end else if (tap_reg == SH_IR) begin
                ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[IR_W-1:1]};
            end
        end else if (tck_fall && !tap_hold && tap_reg == UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // Data path capture and shift
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dr_shift_reg <= '0;
        end else if (tck_rise && !tap_hold) begin
            if (tap_reg == CAP_DR) begin
                dr_shift_reg <= '0;
                case (sel)
                    DR_BSR: begin
                        dr_shift_reg[IN_N-1:0]     <= pin_sync2_reg;
                        dr_shift_reg[BSR_N-1:IN_N] <= pin_out_reg;
                    end
                    DR_ID: begin
                        dr_shift_reg[ID_W-1:0] <= ID_CODE;
                    end
                    DR_OFS: begin
                        dr_shift_reg[OW-1:0]    <= ae_ofs_reg;
                        dr_shift_reg[2*OW-1:OW] <= af_ofs_reg;
                    end
                    default: begin
                        dr_shift_reg[0] <= 1'b0;
                    end
                endcase
            end else if (tap_reg == SH_DR) begin
                dr_shift_reg <= dr_shift(dr_shift_reg, tdi_sync_reg[1],
                                         dr_len(sel));
            end
        end
    end

    // Boundary update stage, loaded only while the boundary chain is in path
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bsr_upd_reg <= '0;
        end else if (tck_fall && !tap_hold && tap_reg == UPD_DR
                     && sel == DR_BSR) begin
            bsr_upd_reg <= dr_shift_reg[BSR_N-1:0];
        end
    end

    // Threshold offsets from test port or dedicated serial path
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ae_ofs_reg <= '0;
            af_ofs_reg <= '0;
        end else if (tck_fall && !tap_hold && tap_reg == UPD_DR
                     && ir_reg == IR_OFS_WRITE) begin
            ae_ofs_reg <= dr_shift_reg[OW-1:0];
            af_ofs_reg <= dr_shift_reg[2*OW-1:OW];
        end else if (ofs_load_in && !tap_hold) begin
            ae_ofs_reg <= ofs_empty_in;
            af_ofs_reg <= ofs_full_in;
        end
    end

    // Serial output changes on the falling link clock edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall && !tap_hold) begin
            tdo_oe_reg <= (tap_reg == SH_DR) || (tap_reg == SH_IR);
            tdo_reg    <= (tap_reg == SH_IR) ? ir_shift_reg[0]
                                             : dr_shift_reg[0];
        end else if (tap_hold) begin
            tdo_oe_reg <= 1'b0;
        end
    end

    // Pin drive by instruction
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
        end else if (tap_hold || ir_reg == IR_HIGHZ) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
        end else if (ir_reg == IR_EXTEST || ir_reg == IR_CLAMP) begin
            pin_out_reg <= bsr_upd_reg[BSR_N-1:IN_N];
            pin_oe_reg  <= '1;
        end else begin
            pin_out_reg <= core_out_in;
            pin_oe_reg  <= core_oe_in;
        end
    end

    // Core input: boundary values under external test, else pins
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            core_in_reg <= '0;
        end else if (ir_reg == IR_EXTEST) begin
            core_in_reg <= bsr_upd_reg[IN_N-1:0];
        end else begin
            core_in_reg <= pin_sync2_reg;
        end
    end

    assign link.tdo                  = tdo_reg;
    assign link.tdo_oe               = tdo_oe_reg;
    assign pin_out_out               = pin_out_reg;
    assign pin_oe_out                = pin_oe_reg;
    assign core_in_out               = core_in_reg;
    assign almost_empty_flag_ofs_out = ae_ofs_reg;
    assign almost_full_flag_ofs_out  = af_ofs_reg;
endmodule : jtag_device_end
`default_nettype wire

// ---- pkg/jtag_pkg.sv ----
// Shared constants, states and helpers for both ends of the test port link.
// Assumes a system clock of 125 MHz on both ends.
package jtag_pkg;
    // Instruction codes, 4-bit field
    localparam int             IR_W           = 4;
    localparam logic [IR_W-1:0] IR_EXTEST     = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE     = 4'h1;
    localparam logic [IR_W-1:0] IR_IDCODE     = 4'h2;
    localparam logic [IR_W-1:0] IR_CLAMP      = 4'h3;
    localparam logic [IR_W-1:0] IR_HIGHZ      = 4'h4;
    localparam logic [IR_W-1:0] IR_OFS_READ   = 4'h7;
    localparam logic [IR_W-1:0] IR_OFS_WRITE  = 4'h8;
    localparam logic [IR_W-1:0] IR_BYPASS     = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE    = 4'h1;
    // Identification register layout
    localparam int ID_W          = 32;
    localparam int ID_VER_POS    = 28;
    localparam int ID_PART_POS   = 12;
    localparam int ID_MAKER_POS  = 1;
    // Default sizes
    localparam int BSR_IN_N      = 24;
    localparam int BSR_OUT_N     = 24;
    localparam int OFS_W         = 16;
    localparam int HOST_DR_MAX   = 64;
    // Link clock timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TCK_PERIOD_NS = 160;
    localparam int TCK_HALF_CYC  = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int RST_TMS_HIGH  = 5;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        DR_BYPASS, DR_BSR, DR_ID, DR_OFS
    } dr_sel_t;

    // Controller next state on a rising link clock edge
    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic tms);
        case (s)
            TLR:     tap_next = tms ? TLR    : RTI;
            RTI:     tap_next = tms ? SEL_DR : RTI;
            SEL_DR:  tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR:  tap_next = tms ? EX1_DR : SH_DR;
            SH_DR:   tap_next = tms ? EX1_DR : SH_DR;
            EX1_DR:  tap_next = tms ? UPD_DR : PA_DR;
            PA_DR:   tap_next = tms ? EX2_DR : PA_DR;
            EX2_DR:  tap_next = tms ? UPD_DR : SH_DR;
            UPD_DR:  tap_next = tms ? SEL_DR : RTI;
            SEL_IR:  tap_next = tms ? TLR    : CAP_IR;
            CAP_IR:  tap_next = tms ? EX1_IR : SH_IR;
            SH_IR:   tap_next = tms ? EX1_IR : SH_IR;
            EX1_IR:  tap_next = tms ? UPD_IR : PA_IR;
            PA_IR:   tap_next = tms ? EX2_IR : PA_IR;
            EX2_IR:  tap_next = tms ? UPD_IR : SH_IR;
            UPD_IR:  tap_next = tms ? SEL_DR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction : tap_next

    // Data register chosen by an instruction; unknown codes pick bypass
    function automatic dr_sel_t dr_select(input logic [IR_W-1:0] ir);
        case (ir)
            IR_EXTEST, IR_SAMPLE:       dr_select = DR_BSR;
            IR_IDCODE:                  dr_select = DR_ID;
            IR_OFS_READ, IR_OFS_WRITE:  dr_select = DR_OFS;
            default:                    dr_select = DR_BYPASS;
        endcase
    endfunction : dr_select
endpackage : jtag_pkg

// ---- pkg/jtag_link_if.sv ----
// Link between the tester end and the device end of the test port.
// Assumes the bench joins both ends; the serial output has a pull-up.
`timescale 1ns/10ps
`default_nettype none
interface jtag_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;
    logic tdo_line;

    // Pin level: driven while enabled, pulled high otherwise
    assign tdo_line = tdo_oe ? tdo : 1'b1;

    modport tester (output tck, output tms, output tdi, output trst_n,
                    input tdo_line);
    modport dut    (input tck, input tms, input tdi, input trst_n,
                    output tdo, output tdo_oe);
endinterface : jtag_link_if
`default_nettype wire

// ---- src/jtag_tester_end.sv ----
// Tester end: makes the link clock by a divider, walks the controller
// through reset, instruction scans and data scans, collects the output.
// Assumes the serial output comes back from another clock domain.
`timescale 1ns/10ps
`default_nettype none
module jtag_tester_end #(
    parameter int HALF = jtag_pkg::TCK_HALF_CYC,
    parameter int DMAX = jtag_pkg::HOST_DR_MAX
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    // Link pins
    jtag_link_if.tester                  link,
    // Command port
    input  wire logic                    start_in,
    input  wire logic                    reset_req_in,
    input  wire logic [jtag_pkg::IR_W-1:0] ir_in,
    input  wire logic [6:0]              dr_bits_in,
    input  wire logic [DMAX-1:0]         dr_data_in,
    input  wire logic                    master_reset_pulse_in,
    output logic                         busy_out,
    output logic                         done_out,
    output logic      [DMAX-1:0]         dr_capture_out,
    output logic                         serial_prog_disable_out
);
    import jtag_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_RST, H_IR_HEAD, H_IR_SHIFT, H_IR_TAIL,
        H_DR_HEAD, H_DR_SHIFT, H_DR_TAIL
    } h_state_t;

    h_state_t         st_reg;
    logic [6:0]       step_reg;
    logic [7:0]       div_reg;
    logic             tck_reg;
    logic             tms_reg;
    logic             tdi_reg;
    logic             trst_n_reg;
    logic [1:0]       tdo_sync_reg;
    logic [IR_W-1:0]  ir_reg;
    logic [6:0]       len_reg;
    logic [DMAX-1:0]  data_reg;
    logic [DMAX-1:0]  cap_reg;
    logic             done_reg;
    logic             spd_reg;
    logic             run;
    logic             tick;
    logic             rise;
    logic [6:0]       last;

    // Last step index of each sequence phase
    function automatic logic [6:0] h_last(input h_state_t s,
                                          input logic [6:0] n);
        case (s)
            H_RST:      h_last = 7'(RST_TMS_HIGH);
            H_IR_HEAD:  h_last = 7'h3;
            H_IR_SHIFT: h_last = 7'(IR_W - 1);
            H_DR_HEAD:  h_last = 7'h2;
            H_DR_SHIFT: h_last = n - 7'h1;
            default:    h_last = 7'h1;
        endcase
    endfunction : h_last

    assign run  = (st_reg != H_IDLE || tck_reg) && !master_reset_pulse_in;
    assign tick = run && (div_reg == 8'(HALF - 1));
    assign rise = tick && !tck_reg;
    assign last = h_last(st_reg, len_reg);

    // Returned serial output, two flip-flops
    always_ff @(posedge clk_in) begin
        tdo_sync_reg <= {tdo_sync_reg[0], link.tdo_line};
    end

    // Link clock divider, still while idle with the clock low or in master reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_reg <= '0;
            tck_reg <= 1'b0;
        end else if (tick) begin
            div_reg <= '0;
            tck_reg <= ~tck_reg;
        end else if (run) begin
            div_reg <= div_reg + 8'h1;
        end
    end

    // Sequencer: advances on each rising link clock edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_reg   <= H_IDLE;
            step_reg <= '0;
            ir_reg   <= IR_BYPASS;
            len_reg  <= '0;
            data_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (st_reg == H_IDLE && !tck_reg && !master_reset_pulse_in) begin
                step_reg <= '0;
                if (reset_req_in) begin
                    st_reg <= H_RST;
                end else if (start_in) begin
                    st_reg   <= H_IR_HEAD;
                    ir_reg   <= ir_in;
                    len_reg  <= dr_bits_in;
                    data_reg <= dr_data_in;
                end
            end else if (rise && st_reg != H_IDLE) begin
                step_reg <= step_reg + 7'h1;
                if (step_reg == last) begin
                    step_reg <= '0;
                    case (st_reg)
                        H_RST:      st_reg <= H_IDLE;
                        H_IR_HEAD:  st_reg <= H_IR_SHIFT;
                        H_IR_SHIFT: st_reg <= H_IR_TAIL;
                        H_IR_TAIL:  st_reg <= (len_reg != 7'h0) ? H_DR_HEAD
                                                                : H_IDLE;
                        H_DR_HEAD:  st_reg <= H_DR_SHIFT;
                        H_DR_SHIFT: st_reg <= H_DR_TAIL;
                        default:    st_reg <= H_IDLE;
                    endcase
                    done_reg <= (st_reg == H_RST) || (st_reg == H_DR_TAIL)
                                || (st_reg == H_IR_TAIL && len_reg == 7'h0);
                end
            end
        end
    end

    // Collect the serial output at each rising edge of a data shift
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cap_reg <= '0;
        end else if (st_reg == H_IDLE && start_in && !tck_reg) begin
            cap_reg <= '0;
        end else if (rise && st_reg == H_DR_SHIFT) begin
            cap_reg[step_reg[5:0]] <= tdo_sync_reg[1];
        end
    end

    // Mode and data levels, set while the link clock is low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tms_reg    <= 1'b1;
            tdi_reg    <= 1'b0;
            trst_n_reg <= 1'b1;
        end else if (!tck_reg) begin
            // Test reset only in the first step, so TMS walks to idle
            trst_n_reg <= !(st_reg == H_RST && step_reg == 7'h0);
            tdi_reg    <= 1'b0;
            case (st_reg)
                H_RST:      tms_reg <= (step_reg != last);
                H_IR_HEAD:  tms_reg <= (step_reg < 7'h2);
                H_IR_SHIFT: begin
                    tms_reg <= (step_reg == last);
                    tdi_reg <= ir_reg[step_reg[1:0]];
                end
                H_IR_TAIL:  tms_reg <= (step_reg == 7'h0);
                H_DR_HEAD:  tms_reg <= (step_reg == 7'h0);
                H_DR_SHIFT: begin
                    tms_reg <= (step_reg == last);
                    tdi_reg <= data_reg[step_reg[5:0]];
                end
                H_DR_TAIL:  tms_reg <= (step_reg == 7'h0);
                default:    tms_reg <= 1'b0;
            endcase
        end
    end

    // Serial programming held off during offset commands
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            spd_reg <= 1'b0;
        end else begin
            spd_reg <= (st_reg != H_IDLE) &&
                       (ir_reg == IR_OFS_READ || ir_reg == IR_OFS_WRITE);
        end
    end

    assign link.tck                = tck_reg;
    assign link.tms                = tms_reg;
    assign link.tdi                = tdi_reg;
    assign link.trst_n             = trst_n_reg;
    assign busy_out                = (st_reg != H_IDLE);
    assign done_out                = done_reg;
    assign dr_capture_out          = cap_reg;
    assign serial_prog_disable_out = spd_reg;
endmodule : jtag_tester_end
`default_nettype wire

// ---- test/jtag_link_properties.sv ----
// Timing checks on the link between the tester end and the device end.
// Assumes the system clock of both ends; link clock halves of 4 clk or more.
`timescale 1ns/10ps
`default_nettype none
module jtag_link_properties (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Link signals
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic tdo_line
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // High phase of the link clock
    sequence s_high; tck [*4]; endsequence
    a_line_pulled_up: assert property (!tdo_oe |-> tdo_line)
        else $error("serial line not pulled high");
    a_reset_quiet: assert property ($fell(sys_rst_in) |->
        !tdo_oe && !tck && tms && trst_n) else $error("bad idle after reset");
    a_trst_clears: assert property ($fell(trst_n) |-> ##[1:4] !tdo_oe)
        else $error("serial output still on after test reset");
    a_high_phase: assert property ($rose(tck) |-> s_high)
        else $error("link clock high phase too short");
    a_low_phase: assert property ($fell(tck) |-> !tck [*4])
        else $error("link clock low phase too short");
    a_tdo_held: assert property ($rose(tck) |=> $stable(tdo) [*3])
        else $error("serial output moved while clock high");
    a_setup_held: assert property ($rose(tck) |-> $stable(tms) && $stable(tdi))
        else $error("mode or data moved at clock rise");
    a_oe_on_fall: assert property ($rose(tdo_oe) |-> !tck)
        else $error("serial output enabled while clock high");
endmodule : jtag_link_properties
`default_nettype wire

// ---- test/testbench.sv ----
// Bench joining both ends of the test port, driving commands and pins.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import jtag_pkg::*;
    logic clk = 0, rst = 1, start = 0, rreq = 0, pwr_dn = 0, ld = 0, mrst = 0;
    logic [3:0] ir = 0;
    logic [6:0] nb = 0;
    logic [63:0] dd = 0, cap;
    logic busy, done, spd, seen, tck0;
    logic [23:0] cout = 24'h3c5a96, coe = 24'h0f0f0f, pin = 24'h81e7a4;
    logic [23:0] cin, pout, poe;
    logic [15:0] ae, af;
    logic [47:0] pre = 48'h5a5a5a123456, q = 48'hc3c3c3654321;
    int n_errors = 0, samples_checked = 0;
    always #4 clk = ~clk;
    jtag_link_if link ();
    jtag_tester_end u_jtag_tester_end (.clk_in(clk),
        .sys_rst_in(rst), .link(link), .start_in(start), .reset_req_in(rreq),
        .ir_in(ir), .dr_bits_in(nb), .dr_data_in(dd), .busy_out(busy),
        .master_reset_pulse_in(mrst), .done_out(done), .dr_capture_out(cap),
        .serial_prog_disable_out(spd));
    jtag_device_end #(.ID_VER(4'h3), .ID_PART(16'h1234), .ID_MAKER(11'h155))
        u_jtag_device_end (.clk_in(clk), .sys_rst_in(rst), .link(link),
        .core_out_in(cout), .core_oe_in(coe), .core_in_out(cin),
        .pin_in_in(pin), .pin_out_out(pout), .pin_oe_out(poe),
        .power_down_input_in(pwr_dn), .ofs_load_in(ld),
        .ofs_empty_in(16'h0123), .ofs_full_in(16'h0456),
        .almost_empty_flag_ofs_out(ae), .almost_full_flag_ofs_out(af));
    jtag_link_properties u_jtag_link_properties (.clk_in(clk),
        .sys_rst_in(rst), .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .trst_n(link.trst_n), .tdo(link.tdo), .tdo_oe(link.tdo_oe),
        .tdo_line(link.tdo_line));
    // Verdict and end of run
    task automatic complete_run();
        $display("Mismatches %0d of %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One command: reset sequence or instruction scan, then a data scan of n bits if n is not 0
    task automatic cmd(input logic r, input logic [3:0] i,
                       input logic [6:0] n, input logic [63:0] d);
        int k;
        seen = 0;
        @(posedge clk);
        ir <= i;
        nb <= n;
        dd <= d;
        start <= !r;
        rreq <= r;
        // Hold the request until the tester has taken it
        for (k = 0; k < 100 && busy !== 1'b1; k++) begin
            @(posedge clk);
        end
        start <= 0;
        rreq <= 0;
        while (k < 2000 && done !== 1'b1) begin
            @(posedge clk);
            if (spd === 1'b1) seen = 1;
            k++;
        end
        if (k == 2000) begin
            n_errors++;
            complete_run();
        end
        @(posedge clk);
    endtask : cmd
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        ld <= 1;
        @(posedge clk);
        ld <= 0;
        cmd(1, 0, 0, 0);
        chk({af, ae}, 32'h04560123);
        cmd(0, IR_IDCODE, 32, 0);
        chk(cap[31:0], {4'h3, 16'h1234, 11'h155, 1'b1});
        cmd(0, IR_SAMPLE, 48, pre);
        chk(cap[47:0], {cout, pin});
        chk({poe, pout}, {coe, cout});
        cmd(0, IR_EXTEST, 0, 0);
        chk({poe, pout}, {24'hffffff, pre[47:24]});
        cmd(0, IR_EXTEST, 48, q);
        chk(cap[23:0], pin);
        chk({pout, cin}, q);
        cmd(0, IR_CLAMP, 8, 8'ha5);
        chk(cap[7:0], 8'h4a);
        chk({poe, pout}, {24'hffffff, q[47:24]});
        cmd(0, IR_HIGHZ, 8, 8'ha5);
        chk(cap[7:0], 8'h4a);
        chk({poe, pout}, 48'h0);
        // Bypass and every code without a defined meaning
        for (int c = 5; c < 16; c++) begin
            if (c != 7 && c != 8) begin
                cmd(0, c[3:0], 8, 8'ha5);
                chk(cap[7:0], 8'h4a);
                chk({poe, pout}, {coe, cout});
            end
        end
        cmd(0, IR_OFS_WRITE, 32, 64'hbeef1357);
        chk({af, ae, 7'h0, seen}, 40'hbeef135701);
        cmd(0, IR_OFS_READ, 32, 0);
        chk({cap[31:0], 7'h0, seen}, 40'hbeef135701);
        // Link clock stands still through a master reset in mid-scan
        fork
            cmd(0, IR_BYPASS, 8, 8'ha5);
            begin
                repeat (300) @(posedge clk);
                mrst <= 1;
                @(posedge clk);
                tck0 = link.tck;
                repeat (40) begin
                    @(posedge clk);
                    chk(link.tck, tck0);
                end
                mrst <= 0;
            end
        join
        chk(cap[7:0], 8'h4a);
        pwr_dn <= 1;
        cmd(0, IR_BYPASS, 8, 8'ha5);
        chk({poe, cap[7:0]}, 32'hff);
        ld <= 1;
        @(posedge clk);
        ld <= 0;
        @(posedge clk);
        chk({af, ae}, 32'hbeef1357);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
